// ===== src/ssr_pkg.sv
// Constants and carrier types for the status reporting block
package ssr_pkg;
  localparam int DW = 16;
  localparam int NG = 5;
  // Register groups
  localparam int G_OPER = 0;
  localparam int G_QUES = 1;
  localparam int G_FREQ = 2;
  localparam int G_LIM = 3;
  localparam int G_POW = 4;
  // Part within a group, address bits [2:0]; group is address bits [5:3]
  localparam logic [2:0] P_COND = 3'h0;
  localparam logic [2:0] P_EVENT = 3'h1;
  localparam logic [2:0] P_ENABLE = 3'h2;
  localparam logic [2:0] P_PTR = 3'h3;
  localparam logic [2:0] P_NTR = 3'h4;
  // Control registers
  localparam logic [7:0] A_CMD = 8'h28;
  localparam logic [7:0] A_ERRQ = 8'h29;
  localparam logic [7:0] A_SRE = 8'h2A;
  localparam logic [7:0] A_STB = 8'h2B;
  localparam logic [7:0] A_INT_STAT = 8'h2C;
  localparam logic [7:0] A_INT_MASK = 8'h2D;
  localparam logic [7:0] A_ERR_CNT = 8'h2E;
  localparam int CMD_PRESET_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;
  // Questionable condition bits fed by the sub-register summaries
  localparam int QUES_FREQ_BIT = 8;
  localparam int QUES_LIM_BIT = 9;
  localparam int QUES_POW_BIT = 10;
  // Preset and reset values
  localparam logic [DW-1:0] PTR_PRESET = 16'hFFFF;
  localparam logic [DW-1:0] NTR_PRESET = 16'h0000;
  localparam logic [DW-1:0] TOP_ENA_PRESET = 16'h0000;
  localparam logic [DW-1:0] SUB_ENA_PRESET = 16'hFFFF;
  // Status byte
  localparam int STB_ERRQ = 2;
  localparam int STB_QUES = 3;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_OPER = 7;
  localparam logic [7:0] STB_SRQ_MASK = 8'hBC;
  // Interrupt status bits
  localparam int IW = 4;
  localparam int INT_OPER = 0;
  localparam int INT_QUES = 1;
  localparam int INT_ERR = 2;
  localparam int INT_OVF = 3;
  localparam int ERR_DEPTH = 8;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [DW-1:0] wdata;
  } ssr_bus_t;

  typedef struct packed {
    logic valid;
    logic signed [DW-1:0] code;
  } ssr_err_t;
endpackage : ssr_pkg

// ===== src/ssr_status_regs.sv
// Status reporting registers: operation, questionable and sub-registers, error queue, status byte
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
module ssr_status_regs #(
  parameter int ERR_DEPTH = ssr_pkg::ERR_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire ssr_pkg::ssr_bus_t bus,
  output logic [ssr_pkg::DW-1:0] rdata_ff,
  input wire logic [ssr_pkg::NG-1:0][ssr_pkg::DW-1:0] cond_pin,
  input wire ssr_pkg::ssr_err_t err,
  input wire logic mav_in,
  input wire logic esb_in,
  output logic oper_sum_ff,
  output logic ques_sum_ff,
  output logic srq_ff,
  output logic irq_ff
);
  localparam int NG = ssr_pkg::NG;
  localparam int DW = ssr_pkg::DW;
  localparam int AW = $clog2(ERR_DEPTH);
  localparam int CW = AW + 1;

  function automatic logic reg_hit(input logic [7:0] a, input int g, input logic [2:0] p);
    reg_hit = (a == {2'b00, 3'(g), p});
  endfunction : reg_hit

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [NG-1:0][DW-1:0] sync1_ff;
  logic [NG-1:0][DW-1:0] sync2_ff;
  logic [NG-1:0][DW-1:0] cond_ff;
  logic [NG-1:0][DW-1:0] evt_ff;
  logic [NG-1:0][DW-1:0] ena_ff;
  logic [NG-1:0][DW-1:0] ptr_ff;
  logic [NG-1:0][DW-1:0] ntr_ff;
  logic [NG-1:0] sum_ff;
  logic [NG-1:0][DW-1:0] cond_src;
  logic [NG-1:0][DW-1:0] pos_set;
  logic [NG-1:0][DW-1:0] neg_set;
  logic [NG-1:0][DW-1:0] nxt_evt;
  logic [NG-1:0] nxt_sum;
  logic [NG-1:0] rd_evt;
  logic [NG-1:0] wr_ena;
  logic [NG-1:0] wr_ptr;
  logic [NG-1:0] wr_ntr;
  logic signed [DW-1:0] errq_mem [ERR_DEPTH];
  logic [AW-1:0] err_wp_ff;
  logic [AW-1:0] err_rp_ff;
  logic [CW-1:0] err_cnt_ff;
  logic [CW-1:0] nxt_err_cnt;
  logic [7:0] sre_ff;
  logic [ssr_pkg::IW-1:0] int_stat_ff;
  logic [ssr_pkg::IW-1:0] int_mask_ff;
  logic [ssr_pkg::IW-1:0] int_ev;
  logic [ssr_pkg::IW-1:0] nxt_int_stat;
  logic [7:0] stb;
  logic [DW-1:0] rd_val;
  logic [DW-1:0] ques_merged;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  wire cmd_wr = bus.wr && (bus.addr == ssr_pkg::A_CMD);
  wire preset = cmd_wr && bus.wdata[ssr_pkg::CMD_PRESET_BIT];
  wire clear = cmd_wr && bus.wdata[ssr_pkg::CMD_CLEAR_BIT];
  wire errq_rd = bus.rd && (bus.addr == ssr_pkg::A_ERRQ);
  wire sre_wr = bus.wr && (bus.addr == ssr_pkg::A_SRE);
  wire int_stat_wr = bus.wr && (bus.addr == ssr_pkg::A_INT_STAT);
  wire int_mask_wr = bus.wr && (bus.addr == ssr_pkg::A_INT_MASK);
  wire err_empty = (err_cnt_ff == '0);
  wire err_full = (err_cnt_ff == CW'(ERR_DEPTH));
  wire err_pop = errq_rd && !err_empty && !clear;
  wire err_push = err.valid && !err_full && !clear;
  wire err_ovf = err.valid && err_full && !clear;

  for (genvar g = 0; g < NG; g++) begin : g_dec
    assign rd_evt[g] = bus.rd && reg_hit(bus.addr, g, ssr_pkg::P_EVENT);
    assign wr_ena[g] = bus.wr && reg_hit(bus.addr, g, ssr_pkg::P_ENABLE);
    assign wr_ptr[g] = bus.wr && reg_hit(bus.addr, g, ssr_pkg::P_PTR);
    assign wr_ntr[g] = bus.wr && reg_hit(bus.addr, g, ssr_pkg::P_NTR);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition sources
  // Calibration state drives the operation conditions; oscillator and
  // overload state the questionable ones; limit results the limit group.
  // No operating mode input exists, so every mode sees the same logic.
  always_comb begin
    ques_merged = sync2_ff[ssr_pkg::G_QUES];
    ques_merged[ssr_pkg::QUES_FREQ_BIT] = sum_ff[ssr_pkg::G_FREQ];
    ques_merged[ssr_pkg::QUES_LIM_BIT] = sum_ff[ssr_pkg::G_LIM];
    ques_merged[ssr_pkg::QUES_POW_BIT] = sum_ff[ssr_pkg::G_POW];
  end

  for (genvar g = 0; g < NG; g++) begin : g_src
    if (g == ssr_pkg::G_QUES) begin : g_q
      assign cond_src[g] = ques_merged;
    end else begin : g_o
      assign cond_src[g] = sync2_ff[g];
    end
    assign pos_set[g] = ptr_ff[g] & cond_src[g] & ~cond_ff[g];
    assign neg_set[g] = ntr_ff[g] & ~cond_src[g] & cond_ff[g];
    // A new transition wins over a read clear in the same cycle
    assign nxt_evt[g] = ((rd_evt[g] || clear) ? '0 : evt_ff[g]) | pos_set[g] | neg_set[g];
    assign nxt_sum[g] = |(evt_ff[g] & ena_ff[g]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register parts
  // The preset values also apply at power on; no other command touches them.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      cond_ff <= '0;
      evt_ff <= '0;
      sum_ff <= '0;
    end else begin
      sync1_ff <= cond_pin;
      sync2_ff <= sync1_ff;
      cond_ff <= cond_src;
      evt_ff <= nxt_evt;
      sum_ff <= nxt_sum;
    end
  end

  for (genvar g = 0; g < NG; g++) begin : g_cfg
    localparam logic [DW-1:0] ENA_RST =
      (g == ssr_pkg::G_OPER || g == ssr_pkg::G_QUES) ? ssr_pkg::TOP_ENA_PRESET : ssr_pkg::SUB_ENA_PRESET;
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        ena_ff[g] <= ENA_RST;
        ptr_ff[g] <= ssr_pkg::PTR_PRESET;
        ntr_ff[g] <= ssr_pkg::NTR_PRESET;
      end else if (preset) begin
        ena_ff[g] <= ENA_RST;
        ptr_ff[g] <= ssr_pkg::PTR_PRESET;
        ntr_ff[g] <= ssr_pkg::NTR_PRESET;
      end else begin
        if (wr_ena[g]) begin
          ena_ff[g] <= bus.wdata;
        end
        if (wr_ptr[g]) begin
          ptr_ff[g] <= bus.wdata;
        end
        if (wr_ntr[g]) begin
          ntr_ff[g] <= bus.wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error queue
  // Codes are stored signed as given: device errors positive, standard
  // errors negative. A full queue drops the newest entry and flags it.
  assign nxt_err_cnt = clear ? '0 : err_cnt_ff + CW'(err_push) - CW'(err_pop);

  always_ff @(posedge ref_clk) begin
    if (err_push) begin
      errq_mem[err_wp_ff] <= err.code;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_wp_ff <= '0;
      err_rp_ff <= '0;
      err_cnt_ff <= '0;
    end else begin
      err_cnt_ff <= nxt_err_cnt;
      if (clear) begin
        err_wp_ff <= '0;
        err_rp_ff <= '0;
      end else begin
        if (err_push) begin
          err_wp_ff <= (err_wp_ff == AW'(ERR_DEPTH - 1)) ? '0 : err_wp_ff + AW'(1);
        end
        if (err_pop) begin
          err_rp_ff <= (err_rp_ff == AW'(ERR_DEPTH - 1)) ? '0 : err_rp_ff + AW'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte and service request
  always_comb begin
    stb = 8'h00;
    stb[ssr_pkg::STB_ERRQ] = !err_empty;
    stb[ssr_pkg::STB_QUES] = sum_ff[ssr_pkg::G_QUES];
    stb[ssr_pkg::STB_MAV] = mav_in;
    stb[ssr_pkg::STB_ESB] = esb_in;
    stb[ssr_pkg::STB_OPER] = sum_ff[ssr_pkg::G_OPER];
  end

  wire srq_req = |(stb & sre_ff & ssr_pkg::STB_SRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  always_comb begin
    int_ev = '0;
    int_ev[ssr_pkg::INT_OPER] = nxt_sum[ssr_pkg::G_OPER] && !sum_ff[ssr_pkg::G_OPER];
    int_ev[ssr_pkg::INT_QUES] = nxt_sum[ssr_pkg::G_QUES] && !sum_ff[ssr_pkg::G_QUES];
    int_ev[ssr_pkg::INT_ERR] = err_push;
    int_ev[ssr_pkg::INT_OVF] = err_ovf;
  end

  // Set wins over a write-one clear in the same cycle
  assign nxt_int_stat = (int_stat_ff & ~(int_stat_wr ? bus.wdata[ssr_pkg::IW-1:0] : '0)) | int_ev;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sre_ff <= 8'h00;
      int_stat_ff <= '0;
      int_mask_ff <= '0;
      irq_ff <= 1'b0;
      srq_ff <= 1'b0;
      oper_sum_ff <= 1'b0;
      ques_sum_ff <= 1'b0;
    end else begin
      if (sre_wr) begin
        sre_ff <= bus.wdata[7:0];
      end
      if (int_mask_wr) begin
        int_mask_ff <= bus.wdata[ssr_pkg::IW-1:0];
      end
      int_stat_ff <= nxt_int_stat;
      irq_ff <= |(nxt_int_stat & (int_mask_wr ? bus.wdata[ssr_pkg::IW-1:0] : int_mask_ff));
      srq_ff <= srq_req;
      oper_sum_ff <= nxt_sum[ssr_pkg::G_OPER];
      ques_sum_ff <= nxt_sum[ssr_pkg::G_QUES];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  wire [2:0] rd_grp = bus.addr[5:3];
  wire grp_ok = (bus.addr[7:6] == 2'b00) && (rd_grp < 3'(NG));

  always_comb begin
    rd_val = '0;
    if (grp_ok) begin
      unique case (bus.addr[2:0])
        ssr_pkg::P_COND: rd_val = cond_ff[rd_grp];
        ssr_pkg::P_EVENT: rd_val = evt_ff[rd_grp];
        ssr_pkg::P_ENABLE: rd_val = ena_ff[rd_grp];
        ssr_pkg::P_PTR: rd_val = ptr_ff[rd_grp];
        ssr_pkg::P_NTR: rd_val = ntr_ff[rd_grp];
        default: rd_val = '0;
      endcase
    end else begin
      unique case (bus.addr)
        ssr_pkg::A_ERRQ: rd_val = err_empty ? '0 : errq_mem[err_rp_ff];
        ssr_pkg::A_SRE: rd_val = {8'h00, sre_ff};
        ssr_pkg::A_STB: rd_val = {8'h00, stb};
        ssr_pkg::A_INT_STAT: rd_val = DW'(int_stat_ff);
        ssr_pkg::A_INT_MASK: rd_val = DW'(int_mask_ff);
        ssr_pkg::A_ERR_CNT: rd_val = DW'(err_cnt_ff);
        default: rd_val = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= bus.rd ? rd_val : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_preset_ptr_fill: assert property (preset |=> ptr_ff == {NG{ssr_pkg::PTR_PRESET}})
    else $error("ptr not filled by preset");
  chk_preset_ntr_clear: assert property (preset |=> ntr_ff == '0)
    else $error("ntr not cleared by preset");
  chk_preset_ena_clear: assert property (preset |=> ena_ff[0] == '0 && ena_ff[1] == '0)
    else $error("top enable not cleared by preset");
  chk_event_read_clear: assert property (
    rd_evt[0] && pos_set[0] == '0 && neg_set[0] == '0 |=> evt_ff[0] == '0 && rdata_ff == $past(evt_ff[0]))
    else $error("event read did not return and clear");
  chk_cond_read_keep: assert property (
    bus.rd && reg_hit(bus.addr, 1, ssr_pkg::P_COND) && !clear |=> evt_ff[1] == $past(evt_ff[1] | pos_set[1] | neg_set[1]))
    else $error("condition read disturbed event");
  chk_pos_edge_set: assert property (pos_set[2] != '0 |=> (evt_ff[2] & $past(pos_set[2])) == $past(pos_set[2]))
    else $error("positive transition not latched");
  chk_neg_edge_set: assert property (neg_set[0] != '0 |=> (evt_ff[0] & $past(neg_set[0])) == $past(neg_set[0]))
    else $error("negative transition not latched");
  chk_event_sticky: assert property (!rd_evt[3] && !clear |=> (evt_ff[3] & $past(evt_ff[3])) == $past(evt_ff[3]))
    else $error("event bit lost");
  chk_summary_rise: assert property ($rose(|(evt_ff[0] & ena_ff[0])) |=> oper_sum_ff)
    else $error("summary did not rise");
  chk_err_empty_zero: assert property (errq_rd && err_empty |=> rdata_ff == '0)
    else $error("empty queue read not zero");
  chk_err_pop_one: assert property (err_pop && !err_push |=> err_cnt_ff == $past(err_cnt_ff) - CW'(1))
    else $error("queue read did not remove entry");
  chk_srq_raise: assert property (srq_req |=> srq_ff)
    else $error("service request not raised");
  chk_srq_drop: assert property (!srq_req |=> !srq_ff)
    else $error("service request without enabled status bit");

  // Configuration parts move only on preset or a write to their own address
  chk_cfg_hold_idle: assert property (
    !bus.wr |=> ena_ff == $past(ena_ff) && ptr_ff == $past(ptr_ff) && ntr_ff == $past(ntr_ff))
    else $error("configuration part changed without a write");
  chk_ptr_store_full: assert property (wr_ptr[0] |=> ptr_ff[0] == $past(bus.wdata))
    else $error("positive filter write not stored");
  chk_ntr_store_full: assert property (wr_ntr[1] |=> ntr_ff[1] == $past(bus.wdata))
    else $error("negative filter write not stored");
  chk_ena_store_full: assert property (wr_ena[1] |=> ena_ff[1] == $past(bus.wdata))
    else $error("enable write not stored");
  // Sub-register enables refill so their summaries keep reaching the questionable level
  chk_preset_sub_fill: assert property (
    preset |=> ena_ff[2] == ssr_pkg::SUB_ENA_PRESET && ena_ff[3] == ssr_pkg::SUB_ENA_PRESET
      && ena_ff[4] == ssr_pkg::SUB_ENA_PRESET)
    else $error("sub-register enable not filled by preset");

  // Condition parts follow the first sync stage two edges later, apart from questionable bits 8 to 10, which take the sub-register summaries
  chk_cond_track_oper: assert property (
    cond_ff[ssr_pkg::G_OPER] == $past(sync1_ff[ssr_pkg::G_OPER], 2))
    else $error("operation condition does not follow its pins");
  chk_cond_track_lim: assert property (
    cond_ff[ssr_pkg::G_LIM] == $past(sync1_ff[ssr_pkg::G_LIM], 2))
    else $error("limit condition does not follow its pins");
  chk_cond_read_data: assert property (
    bus.rd && reg_hit(bus.addr, 0, ssr_pkg::P_COND) |=> rdata_ff == $past(cond_ff[0]))
    else $error("condition read returned wrong pattern");

  // Each sub-register summary lands in its own questionable condition bit
  chk_freq_feed: assert property (
    cond_ff[ssr_pkg::G_QUES][ssr_pkg::QUES_FREQ_BIT] == $past(sum_ff[ssr_pkg::G_FREQ]))
    else $error("frequency summary not fed upward");
  chk_lim_feed: assert property (
    cond_ff[ssr_pkg::G_QUES][ssr_pkg::QUES_LIM_BIT] == $past(sum_ff[ssr_pkg::G_LIM]))
    else $error("limit summary not fed upward");
  chk_pow_feed: assert property (
    cond_ff[ssr_pkg::G_QUES][ssr_pkg::QUES_POW_BIT] == $past(sum_ff[ssr_pkg::G_POW]))
    else $error("power summary not fed upward");

  chk_ques_sum_rise: assert property ($rose(|(evt_ff[1] & ena_ff[1])) |=> ques_sum_ff)
    else $error("questionable summary did not rise");
  chk_oper_sum_gate: assert property (!(|(evt_ff[0] & ena_ff[0])) |=> !oper_sum_ff)
    else $error("operation summary without enabled event");
  chk_ques_sum_gate: assert property (!(|(evt_ff[1] & ena_ff[1])) |=> !ques_sum_ff)
    else $error("questionable summary without enabled event");
  chk_event_clear_cmd: assert property (
    clear && pos_set[0] == '0 && neg_set[0] == '0 |=> evt_ff[0] == '0)
    else $error("clear command left an event bit");

  // A push that meets a clear is dropped; the clear empties the queue
  chk_err_push_one: assert property (
    err_push && !err_pop |=> err_cnt_ff == $past(err_cnt_ff) + CW'(1))
    else $error("pushed entry not counted");
  chk_err_cnt_bound: assert property (err_cnt_ff <= CW'(ERR_DEPTH))
    else $error("error count beyond queue depth");
  chk_err_code_store: assert property (err_push |=> errq_mem[$past(err_wp_ff)] == $past(err.code))
    else $error("error code not stored as given");
  chk_err_clear_empty: assert property (clear |=> err_empty)
    else $error("clear left entries in the error queue");
endmodule : ssr_status_regs

// ===== tb/ssr_ctrl_model.sv
// Remote controller model: issues register writes and reads on the status port
`timescale 1ns/100ps
module ssr_ctrl_model (
  input wire logic ref_clk,
  output ssr_pkg::ssr_bus_t bus,
  input wire logic [ssr_pkg::DW-1:0] rdata_ff
);
  initial bus = '0;

  // Values are 16-bit words, so only 0 to 65535 can ever be sent
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    // Released lines show the inverse so stale values never look valid
    bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'hA5A5};
    @(posedge ref_clk);
    bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'h5A5A};
    #1;
    d = rdata_ff;
  endtask : rd
endmodule : ssr_ctrl_model

// ===== tb/test_status_reporting_registers.sv
// Self-checking bench for the status reporting registers
`timescale 1ns/100ps
module test_status_reporting_registers;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  ssr_pkg::ssr_bus_t bus;
  logic [ssr_pkg::DW-1:0] rdata_ff;
  logic [ssr_pkg::NG-1:0][ssr_pkg::DW-1:0] cond_pin = '0;
  ssr_pkg::ssr_err_t err = '0;
  logic mav_in = 1'b0;
  logic esb_in = 1'b0;
  logic oper_sum_ff, ques_sum_ff, srq_ff, irq_ff;
  int n_fail = 0;
  int checked = 0;

  always #50 ref_clk = ~ref_clk;

  ssr_ctrl_model u_ctl (.ref_clk(ref_clk), .bus(bus), .rdata_ff(rdata_ff));

  // Shallow queue so the overflow path is reached quickly
  ssr_status_regs #(.ERR_DEPTH(2)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata_ff(rdata_ff), .cond_pin(cond_pin), .err(err),
    .mav_in(mav_in), .esb_in(esb_in), .oper_sum_ff(oper_sum_ff), .ques_sum_ff(ques_sum_ff),
    .srq_ff(srq_ff), .irq_ff(irq_ff)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_ctl.rd(a, d);
    chk(d, exp);
  endtask : rchk

  function automatic logic [7:0] ad(input int g, input logic [2:0] p);
    return 8'(g * 8) | {5'h00, p};
  endfunction : ad

  // Sync plus event latch takes three edges; five leaves margin
  task automatic setc(input int g, input logic [15:0] v);
    @(posedge ref_clk);
    cond_pin[g] <= v;
    repeat (5) @(posedge ref_clk);
  endtask : setc

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    for (int g = 0; g < ssr_pkg::NG; g++) begin
      rchk(ad(g, ssr_pkg::P_PTR), 16'hFFFF);
      rchk(ad(g, ssr_pkg::P_NTR), 16'h0000);
      rchk(ad(g, ssr_pkg::P_ENABLE), (g < 2) ? 16'h0000 : 16'hFFFF);
    end
    rchk(8'h3F, 16'h0000);
    @(posedge ref_clk);
    #1;
    chk(rdata_ff, 16'h0000);
  endtask : t_reset_vals

  task automatic t_rise_irq;
    u_ctl.wr(ad(0, ssr_pkg::P_ENABLE), 16'h0008);
    setc(0, 16'h0008);
    chk(oper_sum_ff, 1'b1);
    chk(irq_ff, 1'b0);
    rchk(ssr_pkg::A_INT_STAT, 16'h0001);
    u_ctl.wr(ssr_pkg::A_INT_MASK, 16'h0001);
    repeat (2) @(posedge ref_clk);
    chk(irq_ff, 1'b1);
    rchk(ad(0, ssr_pkg::P_COND), 16'h0008);
    rchk(ad(0, ssr_pkg::P_EVENT), 16'h0008);
    rchk(ad(0, ssr_pkg::P_EVENT), 16'h0000);
    u_ctl.wr(ssr_pkg::A_INT_STAT, 16'h0001);
    repeat (2) @(posedge ref_clk);
    chk(irq_ff, 1'b0);
    chk(oper_sum_ff, 1'b0);
    setc(0, 16'h0000);
    rchk(ad(0, ssr_pkg::P_EVENT), 16'h0000);
  endtask : t_rise_irq

  task automatic t_fall_latch;
    u_ctl.wr(ad(0, ssr_pkg::P_NTR), 16'h0010);
    u_ctl.wr(ad(0, ssr_pkg::P_PTR), 16'h0000);
    setc(0, 16'h0010);
    rchk(ad(0, ssr_pkg::P_EVENT), 16'h0000);
    setc(0, 16'h0000);
    setc(0, 16'h0010);
    rchk(ad(0, ssr_pkg::P_EVENT), 16'h0010);
    rchk(ad(0, ssr_pkg::P_EVENT), 16'h0000);
    setc(0, 16'h0000);
    rchk(ad(0, ssr_pkg::P_COND), 16'h0000);
    u_ctl.wr(ssr_pkg::A_CMD, 16'h0002);
    rchk(ad(0, ssr_pkg::P_EVENT), 16'h0000);
  endtask : t_fall_latch

  task automatic t_subregs;
    u_ctl.wr(ad(1, ssr_pkg::P_ENABLE), 16'h0700);
    for (int g = 2; g < 5; g++) begin
      setc(g, 16'h0001);
      rchk(ad(1, ssr_pkg::P_COND), 16'h0100 << (g - 2));
      chk(ques_sum_ff, 1'b1);
      rchk(ad(1, ssr_pkg::P_EVENT), 16'h0100 << (g - 2));
      rchk(ad(g, ssr_pkg::P_EVENT), 16'h0001);
      // The cleared sub summary needs two more edges to leave the questionable condition
      repeat (2) @(posedge ref_clk);
      chk(ques_sum_ff, 1'b0);
      rchk(ad(1, ssr_pkg::P_COND), 16'h0000);
      setc(g, 16'h0000);
    end
  endtask : t_subregs

  task automatic t_preset;
    u_ctl.wr(ad(1, ssr_pkg::P_NTR), 16'hA5A5);
    rchk(ad(1, ssr_pkg::P_NTR), 16'hA5A5);
    u_ctl.wr(ad(1, ssr_pkg::P_ENABLE), 16'hFFFF);
    rchk(ad(1, ssr_pkg::P_ENABLE), 16'hFFFF);
    u_ctl.wr(ssr_pkg::A_CMD, 16'h0001);
    for (int g = 0; g < ssr_pkg::NG; g++) begin
      rchk(ad(g, ssr_pkg::P_PTR), 16'hFFFF);
      rchk(ad(g, ssr_pkg::P_NTR), 16'h0000);
      rchk(ad(g, ssr_pkg::P_ENABLE), (g < 2) ? 16'h0000 : 16'hFFFF);
    end
  endtask : t_preset

  task automatic t_errq;
    logic [15:0] d;
    @(posedge ref_clk);
    err <= '{valid: 1'b1, code: 16'hFFFB};
    @(posedge ref_clk);
    err <= '{valid: 1'b1, code: 16'h0003};
    @(posedge ref_clk);
    err <= '{valid: 1'b1, code: 16'h0007};
    @(posedge ref_clk);
    err <= '{valid: 1'b0, code: 16'h0000};
    rchk(ssr_pkg::A_ERR_CNT, 16'h0002);
    u_ctl.rd(ssr_pkg::A_INT_STAT, d);
    chk(d & 16'h000C, 16'h000C);
    rchk(ssr_pkg::A_ERRQ, 16'hFFFB);
    rchk(ssr_pkg::A_ERRQ, 16'h0003);
    rchk(ssr_pkg::A_ERRQ, 16'h0000);
    @(posedge ref_clk);
    err <= '{valid: 1'b1, code: 16'hFFF0};
    @(posedge ref_clk);
    err <= '{valid: 1'b0, code: 16'h0000};
    rchk(ssr_pkg::A_ERR_CNT, 16'h0001);
    u_ctl.wr(ssr_pkg::A_CMD, 16'h0002);
    rchk(ssr_pkg::A_ERR_CNT, 16'h0000);
    rchk(ssr_pkg::A_ERRQ, 16'h0000);
  endtask : t_errq

  task automatic t_srq;
    for (int b = 4; b < 6; b++) begin
      u_ctl.wr(ssr_pkg::A_SRE, 16'h0001 << b);
      @(posedge ref_clk);
      mav_in <= (b == 4);
      esb_in <= (b == 5);
      repeat (4) @(posedge ref_clk);
      chk(srq_ff, 1'b1);
      rchk(ssr_pkg::A_STB, 16'h0001 << b);
      @(posedge ref_clk);
      mav_in <= 1'b0;
      esb_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk(srq_ff, 1'b0);
    end
  endtask : t_srq

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // The whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset_vals();
    t_rise_irq();
    t_fall_latch();
    t_subregs();
    t_preset();
    t_errq();
    t_srq();
    summarize();
  end
endmodule : test_status_reporting_registers
